//--- hw/ptc_pkg.sv
/*
  package for the power and thermal control register bank: offsets, field
  positions, reset values and carriers.
  assumes an AXI4-Lite slave with 32-bit data and byte addressing.
*/
package ptc_pkg;
  // ==========================================================
  // register byte addresses
  localparam logic [11:0] PTC_TEMP_STATUS_LO_ADDR = 12'h040;
  localparam logic [11:0] PTC_TEMP_STATUS_HI_ADDR = 12'h044;
  localparam logic [11:0] PTC_LOW_RATE_ADDR = 12'h04C;
  localparam logic [11:0] PTC_THERMAL_CTRL_ADDR = 12'h050;
  localparam logic [11:0] PTC_POWER_CTRL_ADDR = 12'h054;
  // ==========================================================
  // register indices as printed
  localparam logic [9:0] PTC_TEMP_STATUS_LO_IDX = 10'h010;
  localparam logic [9:0] PTC_TEMP_STATUS_HI_IDX = 10'h011;
  localparam logic [9:0] PTC_LOW_RATE_IDX = 10'h013;
  localparam logic [9:0] PTC_THERMAL_CTRL_IDX = 10'h014;
  localparam logic [9:0] PTC_POWER_CTRL_IDX = 10'h015;
  // ==========================================================
  // field positions
  localparam int PTC_CONV_BIT = 6;
  localparam int PTC_SENSE_BIT = 5;
  localparam int PTC_PUBLISH_BIT = 2;
  localparam int PTC_CHA_BIT = 7;
  localparam int PTC_CHD_BIT = 4;
  localparam int PTC_STANDBY_BIT = 3;
  localparam int PTC_FULL_BIT = 2;
  localparam int PTC_PINFN_BIT = 0;
  // writable masks; other bits are stored as zero
  localparam logic [7:0] PTC_THERMAL_MASK = 8'h64;
  localparam logic [7:0] PTC_POWER_MASK = 8'hFD;
  localparam logic [7:0] PTC_LOW_RATE_MASK = 8'h03;
  localparam logic [7:0] PTC_REG_RESET = 8'h00;
  localparam logic [8:0] PTC_TEMP_RESET = 9'h000;
  // ==========================================================
  // AXI responses
  localparam logic [1:0] PTC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PTC_RESP_SLVERR = 2'h2;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic [3:0] channel_shutdown; // [3]=A .. [0]=D
    logic core_standby;
    logic full_chip_shutdown;
  } ptc_power_s;
  typedef struct packed {
    logic sensor_enable;
    logic thermal_conversion_enable;
  } ptc_sensor_s;
endpackage

//--- hw/ptc_power_combine.sv
/*
  combines the shutdown pin with the power control fields into the
  per-domain power requests.
  assumes shutdown_pin is synchronous to aclk; outputs are registered.
*/
`timescale 1ns/1ns
`default_nettype none
module ptc_power_combine (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic [7:0] power_ctrl, // stored power control register
  input wire logic shutdown_pin, // external shutdown level
  output ptc_pkg::ptc_power_s power_r // registered power requests
);
  // ==========================================================
  // pin routing
  wire pin_fn = power_ctrl[ptc_pkg::PTC_PINFN_BIT];
  wire pin_full = shutdown_pin & ~pin_fn; // [RL8]
  wire pin_standby = shutdown_pin & pin_fn; // [RL9]
  ptc_pkg::ptc_power_s power_nxt;
  assign power_nxt.channel_shutdown =
    power_ctrl[ptc_pkg::PTC_CHA_BIT:ptc_pkg::PTC_CHD_BIT]; // [RL5]
  assign power_nxt.core_standby =
    power_ctrl[ptc_pkg::PTC_STANDBY_BIT] | pin_standby; // [RL6] [RL9]
  assign power_nxt.full_chip_shutdown =
    power_ctrl[ptc_pkg::PTC_FULL_BIT] | pin_full; // [RL7] [RL8]
  always_ff @(posedge aclk) begin
    if (!aresetn) power_r <= '0;
    else power_r <= power_nxt;
  end
endmodule
`default_nettype wire

//--- hw/ptc_regs.sv
/*
  power and thermal control register bank behind an AXI4-Lite slave.
  assumes a sensor macro that returns a 9-bit two's complement result, and
  a shutdown pin synchronous to aclk.
*/
// Overview of operation
// (RL1) low-rate setting 10 one-wire, 11 two-wire
// (RL2) sensor enable bit 5 powers sensor
// (RL3) bit 6 starts conversion, after enable
// (RL4) readout bit 2 publishes 9-bit result
// (RL5) bits 7..4 power down channels A..D
// (RL6) bit 3 puts cores into standby
// (RL7) bit 2 forces full chip shutdown
// (RL8) pin function 0: pin forces shutdown
// (RL9) pin function 1: pin forces standby
// (RL10) low-rate field is bits 1..0
// (RL11) result two's complement, top bits second
// (RL12) software writes zero to reserved bits
`timescale 1ns/1ns
`default_nettype none
module ptc_regs (
  input wire logic aclk, // clock
  input wire logic aresetn, // sync reset, low
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  input wire logic [8:0] sensor_result, // result from sensor macro
  input wire logic shutdown_pin, // external shutdown level
  input wire logic [3:0] ref_status, // reference status {B,D,A,C}
  input wire logic clk_status, // input clock missing flag
  output ptc_pkg::ptc_sensor_s sensor_r, // sensor controls
  output logic [1:0] low_rate_r, // low-rate setting
  output ptc_pkg::ptc_power_s power_r // power requests
);
  // ==========================================================
  // state
  logic [7:0] thermal_ctrl_r;
  logic [7:0] power_ctrl_r;
  logic [8:0] thermal_result_r;
  logic aw_held_r, w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;

  function automatic logic [7:0] wmerge(input logic [7:0] old, input logic [31:0] d,
                                        input logic [3:0] s, input logic [7:0] m);
    wmerge = s[0] ? (d[7:0] & m) : old; // reserved bits kept at zero [RL12]
  endfunction

  // ==========================================================
  // write channel: address and data accepted in either order
  wire aw_ok = s_axi_awvalid & s_axi_awready;
  wire w_ok = s_axi_wvalid & s_axi_wready;
  wire have_aw = aw_held_r | aw_ok;
  wire have_w = w_held_r | w_ok;
  wire [11:0] wa = aw_held_r ? awaddr_r : s_axi_awaddr;
  wire [31:0] wd = w_held_r ? wdata_r : s_axi_wdata;
  wire [3:0] ws = w_held_r ? wstrb_r : s_axi_wstrb;
  wire do_wr = have_aw & have_w & ~s_axi_bvalid;
  wire wr_th = do_wr & (wa == ptc_pkg::PTC_THERMAL_CTRL_ADDR);
  wire wr_pw = do_wr & (wa == ptc_pkg::PTC_POWER_CTRL_ADDR);
  wire wr_lr = do_wr & (wa == ptc_pkg::PTC_LOW_RATE_ADDR);
  wire wr_hit = wr_th | wr_pw | wr_lr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= 12'h000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ptc_pkg::PTC_RESP_OKAY;
    end else begin
      if (aw_ok) begin
        awaddr_r <= s_axi_awaddr;
      end
      if (w_ok) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      aw_held_r <= have_aw & ~do_wr;
      w_held_r <= have_w & ~do_wr;
      s_axi_awready <= ~(have_aw & ~do_wr) & ~do_wr & ~(s_axi_bvalid & ~s_axi_bready);
      s_axi_wready <= ~(have_w & ~do_wr) & ~do_wr & ~(s_axi_bvalid & ~s_axi_bready);
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? ptc_pkg::PTC_RESP_OKAY : ptc_pkg::PTC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      thermal_ctrl_r <= ptc_pkg::PTC_REG_RESET;
      power_ctrl_r <= ptc_pkg::PTC_REG_RESET;
      low_rate_r <= 2'h0;
    end else begin
      if (wr_th) thermal_ctrl_r <= wmerge(thermal_ctrl_r, wd, ws, ptc_pkg::PTC_THERMAL_MASK);
      if (wr_pw) power_ctrl_r <= wmerge(power_ctrl_r, wd, ws, ptc_pkg::PTC_POWER_MASK);
      // stored as written; the legal codes are software's duty [RL1] [RL10]
      if (wr_lr & ws[0]) low_rate_r <= wd[1:0];
    end
  end

  // ==========================================================
  // sensor controls and result capture
  wire sense_en = thermal_ctrl_r[ptc_pkg::PTC_SENSE_BIT];
  // conversion gated by enable so an early start stays harmless [RL3]
  wire conv_en = thermal_ctrl_r[ptc_pkg::PTC_CONV_BIT] & sense_en;
  wire publish = thermal_ctrl_r[ptc_pkg::PTC_PUBLISH_BIT];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sensor_r <= '0;
      thermal_result_r <= ptc_pkg::PTC_TEMP_RESET;
    end else begin
      sensor_r.sensor_enable <= sense_en; // [RL2]
      sensor_r.thermal_conversion_enable <= conv_en; // [RL3]
      if (publish & conv_en) thermal_result_r <= sensor_result; // [RL4]
    end
  end

  ptc_power_combine u_power (
    .aclk(aclk),
    .aresetn(aresetn),
    .power_ctrl(power_ctrl_r),
    .shutdown_pin(shutdown_pin),
    .power_r(power_r)
  );

  // ==========================================================
  // read path; status bits shared with reference status [RL4] [RL11]
  wire [8:0] tr = thermal_result_r;
  wire [7:0] lo_temp = {tr[2], tr[1], tr[0], clk_status, tr[6:4], tr[3]};
  wire [7:0] lo_ref = {ref_status[3], ref_status[2], ref_status[1], clk_status,
                       3'h0, ref_status[0]};
  wire [7:0] lo_val = publish ? lo_temp : lo_ref;
  wire [7:0] hi_val = publish ? {2'h0, tr[8:7], 4'h0} : 8'h00;
  wire [11:0] ra = s_axi_araddr;
  wire rd_lo = ra == ptc_pkg::PTC_TEMP_STATUS_LO_ADDR;
  wire rd_hi = ra == ptc_pkg::PTC_TEMP_STATUS_HI_ADDR;
  wire rd_lr = ra == ptc_pkg::PTC_LOW_RATE_ADDR;
  wire rd_th = ra == ptc_pkg::PTC_THERMAL_CTRL_ADDR;
  wire rd_pw = ra == ptc_pkg::PTC_POWER_CTRL_ADDR;
  wire [7:0] rbyte = rd_lo ? lo_val :
                     rd_hi ? hi_val :
                     rd_lr ? {6'h00, low_rate_r} :
                     rd_th ? thermal_ctrl_r :
                     rd_pw ? power_ctrl_r : 8'h00;
  wire rd_hit = rd_lo | rd_hi | rd_lr | rd_th | rd_pw;
  wire ar_ok = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= ptc_pkg::PTC_RESP_OKAY;
    end else if (ar_ok) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {24'h000000, rbyte};
      s_axi_rresp <= rd_hit ? ptc_pkg::PTC_RESP_OKAY : ptc_pkg::PTC_RESP_SLVERR;
    end else if (s_axi_rvalid & s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- test/ptc_regs_sva.sv
/*
  checker for the power and thermal register bank, bound to ptc_regs.
  assumes an AXI4-Lite master that keeps the handshake rules.
*/
`timescale 1ns/1ns
`default_nettype none
module ptc_regs_sva (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset, low
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic shutdown_pin, // pin level
  input wire ptc_pkg::ptc_sensor_s sensor_r, // sensor controls
  input wire ptc_pkg::ptc_power_s power_r // power requests
);
  // ==========================================================
  // properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_gate;
    sensor_r.thermal_conversion_enable |-> sensor_r.sensor_enable;
  endproperty
  property p_pin;
    shutdown_pin |=> power_r.full_chip_shutdown || power_r.core_standby;
  endproperty
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_rans;
    s_rd |=> s_axi_rvalid;
  endproperty
  property p_bans;
    s_wr |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endproperty
  property p_arbusy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  property p_sens;
    $changed(sensor_r) |-> s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_gate: assert property (p_gate) else $error("conversion without sensor");
  a_pin: assert property (p_pin) else $error("pin ignored");
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");
  a_rhold: assert property (p_rhold) else $error("rvalid dropped");
  a_rans: assert property (p_rans) else $error("no read answer");
  a_bans: assert property (p_bans) else $error("no write answer");
  a_arbusy: assert property (p_arbusy) else $error("arready while busy");
  a_sens: assert property (p_sens) else $error("sensor moved alone");
endmodule
bind ptc_regs ptc_regs_sva ptc_regs_sva_inst (.*);
`default_nettype wire

//--- test/tb_top.sv
/*
  self-checking bench for ptc_regs with an integer model.
  assumes byte 0 carries each register; strobes held at all ones.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
  logic pin = 0, clks = 0, awr, wrd, bv, arr, rv;
  logic [11:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rdata, rd, d;
  logic [3:0] refs = '0;
  logic [8:0] sres = '0;
  logic [1:0] bresp, rresp, lr, rsp;
  ptc_pkg::ptc_sensor_s sen;
  ptc_pkg::ptc_power_s pwr;
  logic [31:0] lfsr = 32'h32489E9D;
  int err_total = 0, checks = 0, i;
  always #5 aclk = ~aclk;
  ptc_regs ptc_regs_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .sensor_result(sres), .shutdown_pin(pin), .ref_status(refs), .clk_status(clks),
    .sensor_r(sen), .low_rate_r(lr), .power_r(pwr));
  // ==========================================================
  // helpers
  function logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task finish_test;
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task axw(input logic [11:0] a, input logic [31:0] v);
    int n;
    n = 0;
    awa <= a; wd <= v; awv <= 1; wv <= 1; bry <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end while (bv !== 1'b1 && n < 50);
    rsp = bresp;
    bry <= 0;
    if (n >= 50) begin err_total++; finish_test; end
    repeat (2) @(posedge aclk);
  endtask
  task axr(input logic [11:0] a);
    int n;
    n = 0;
    ara <= a; arv <= 1; rry <= 1;
    do begin
      @(posedge aclk);
      n++;
      if (arr) arv <= 0;
    end while (rv !== 1'b1 && n < 50);
    rd = rdata; rsp = rresp;
    rry <= 0;
    if (n >= 50) begin err_total++; finish_test; end
    @(posedge aclk);
  endtask
  // ==========================================================
  // scenarios
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    axr(ptc_pkg::PTC_THERMAL_CTRL_ADDR); chk(rd, 32'h0);
    axr(ptc_pkg::PTC_POWER_CTRL_ADDR); chk(rd, 32'h0);
    for (i = 0; i < 8; i++) begin
      d = rnd();
      axw(ptc_pkg::PTC_THERMAL_CTRL_ADDR, d);
      axr(ptc_pkg::PTC_THERMAL_CTRL_ADDR); chk(rd, d & 32'h64);
      chk(32'(sen), 32'({d[5], d[6] & d[5]}));
    end
    for (i = 0; i < 16; i++) begin
      d = rnd(); d[0] = i[0]; d[8] = i[1];
      pin <= d[8];
      axw(ptc_pkg::PTC_POWER_CTRL_ADDR, d);
      axr(ptc_pkg::PTC_POWER_CTRL_ADDR); chk(rd, d & 32'hFD);
      chk(32'(pwr), 32'({d[7:4], d[3] | d[8] & d[0], d[2] | d[8] & !d[0]}));
    end
    for (i = 0; i < 4; i++) begin
      axw(ptc_pkg::PTC_LOW_RATE_ADDR, (rnd() & 32'hFC) | i);
      chk(32'(lr), i);
    end
    axw(ptc_pkg::PTC_THERMAL_CTRL_ADDR, 32'h64);
    for (i = 0; i < 8; i++) begin
      d = rnd();
      sres <= d[8:0]; refs <= d[12:9]; clks <= d[13];
      repeat (3) @(posedge aclk);
      axr(ptc_pkg::PTC_TEMP_STATUS_LO_ADDR); chk(rd, {d[2:0], d[13], d[6:4], d[3]});
      axr(ptc_pkg::PTC_TEMP_STATUS_HI_ADDR); chk(rd, {d[8:7], 4'h0});
    end
    axw(ptc_pkg::PTC_THERMAL_CTRL_ADDR, 32'h60);
    axr(ptc_pkg::PTC_TEMP_STATUS_HI_ADDR); chk(rd, 32'h0);
    axr(ptc_pkg::PTC_TEMP_STATUS_LO_ADDR); chk(rd, {refs[3:1], clks, 3'h0, refs[0]});
    axw(12'h058, 32'hFF); chk(rsp, ptc_pkg::PTC_RESP_SLVERR);
    axr(12'h058); chk(rsp, ptc_pkg::PTC_RESP_SLVERR);
    finish_test;
  end
endmodule
`default_nettype wire
